// ===== rtl/mpmc_cfg.svh
// register offsets, field positions, reset values and timing figures of the power-mode sequencer
`ifndef MPMC_CFG_SVH
`define MPMC_CFG_SVH

// =====================================================
// register offsets (7-bit link address)
`define MPMC_ADDR_ID 7'h40
`define MPMC_ADDR_RES 7'h42
`define MPMC_ADDR_PWR 7'h4b
`define MPMC_ADDR_OPM 7'h4c
`define MPMC_ADDR_REPXY 7'h55
`define MPMC_ADDR_REPZ 7'h56
`define MPMC_ADDR_TRIM 7'h5d

// =====================================================
// field positions and codes
`define MPMC_PWR_ON_BIT 0
`define MPMC_PWR_SRST_BIT 1
`define MPMC_PWR_MASK 8'h05
`define MPMC_OPM_MASK 8'h0e
`define MPMC_OPM_LO 1
`define MPMC_OPM_HI 2
`define MPMC_ODR_BIT 3
`define MPMC_CODE_NORMAL 2'h0
`define MPMC_CODE_FORCED 2'h1
`define MPMC_CODE_SLEEP 2'h3

// =====================================================
// reset values
`define MPMC_PWR_RST 8'h00
`define MPMC_OPM_RST 8'h06
`define MPMC_REP_RST 8'h00

// =====================================================
// timing
`define MPMC_CLK_NS 10
`define MPMC_T_XY_US 145
`define MPMC_T_Z_US 500
`define MPMC_T_BASE_US 980
`define MPMC_ODR_HZ 10

`endif

// ===== rtl/mpmc_pkg.sv
// types of the power-mode sequencer
package mpmc_pkg;
  typedef enum logic [2:0] {
    MPMC_BOOT,
    MPMC_SUSPEND,
    MPMC_SLEEP,
    MPMC_NORMAL,
    MPMC_FORCED
  } mpmc_state_e;
endpackage

// ===== rtl/mpmc_spi_rx.sv
// link-clock side of the host port: shifts in command and write bytes
`timescale 1ns/1ps
`default_nettype none
module mpmc_spi_rx (
  // reset
  input wire logic rst,
  // link pins
  input wire logic link_sck,
  input wire logic link_csb,
  input wire logic link_sdi,
  // requests to the system domain, held until the next byte
  output logic rd_tgl,
  output logic wr_tgl,
  output logic [6:0] req_addr,
  output logic [7:0] req_data
);
  logic [2:0] bit_cnt;
  logic cmd_phase;
  logic [6:0] sh;
  logic is_read;
  logic [6:0] cur_addr;
  logic [7:0] byte_in;

  assign byte_in = {sh, link_sdi};

  // =====================================================
  // frame position, cleared by the frame's own select
  always_ff @(posedge link_sck or posedge link_csb) begin
    if (link_csb) begin
      bit_cnt <= 3'h0;
      cmd_phase <= 1'b1;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        cmd_phase <= 1'b0;
      end
    end
  end

  // =====================================================
  // byte capture and request toggles
  always_ff @(posedge link_sck or posedge rst) begin
    if (rst) begin
      sh <= 7'h00;
      is_read <= 1'b0;
      cur_addr <= 7'h00;
      req_addr <= 7'h00;
      req_data <= 8'h00;
      rd_tgl <= 1'b0;
      wr_tgl <= 1'b0;
    end else begin
      sh <= byte_in[6:0];
      if (bit_cnt == 3'h7) begin
        if (cmd_phase) begin
          is_read <= byte_in[7];
          cur_addr <= byte_in[6:0];
          if (byte_in[7]) begin
            req_addr <= byte_in[6:0];
            rd_tgl <= ~rd_tgl;
          end
        end else if (!is_read) begin
          req_addr <= cur_addr;
          req_data <= byte_in;
          wr_tgl <= ~wr_tgl;
          cur_addr <= cur_addr + 7'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/mpmc_top.sv
// power-mode sequencer of a three-axis magnetic sensor
// Behaviour
// - device is only a target on host port
// - power-on reset sets logic and registers default
// - after reset copy trim, then enter suspend
// - suspend allows only power control register access
// - suspend keeps power control and trim copy, clears other registers
// - suspended identifier read: zero or released line
// - power bit one in suspend gives sleep
// - mode code 11 from active gives sleep
// - sleep gives full register access
// - power bit zero from awake gives suspend
// - normal or forced mode write from sleep enters active measuring
// - normal mode measures once per data-rate period
// - soft reset in normal mode gives sleep
// - forced measures once, sets code 11, sleeps
// - retriggered forced measurement discards partial result
`include "mpmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mpmc_top
  import mpmc_pkg::*;
#(
  parameter logic [7:0] DEV_ID = 8'h5a, // arbitrary value
  parameter int TRIM_WORDS = 4,
  parameter logic [31:0] T_XY_CYC = 32'(`MPMC_T_XY_US * 1000 / `MPMC_CLK_NS),
  parameter logic [31:0] T_Z_CYC = 32'(`MPMC_T_Z_US * 1000 / `MPMC_CLK_NS),
  parameter logic [31:0] T_BASE_CYC = 32'(`MPMC_T_BASE_US * 1000 / `MPMC_CLK_NS),
  parameter logic [31:0] ODR_CYC = 32'(1000000000 / (`MPMC_ODR_HZ * `MPMC_CLK_NS))
) (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // host link
  input wire logic link_sck,
  input wire logic link_csb,
  input wire logic link_sdi,
  input wire logic proto_i2c,
  output logic link_sdo,
  output logic link_sdo_oe,
  // trim store
  output logic [7:0] trim_addr,
  input wire logic [7:0] trim_data,
  // measurement front end
  input wire logic [7:0] meas_sample,
  output logic meas_active,
  // status
  output var mpmc_state_e power_mode
);
  logic rx_rd_tgl;
  logic rx_wr_tgl;
  logic [6:0] rx_addr;
  logic [7:0] rx_wdata;
  logic [2:0] rd_sy;
  logic [2:0] wr_sy;
  logic [2:0] sck_sy;
  logic [1:0] csb_sy;
  logic [1:0] i2c_sy;
  logic rd_fire;
  logic wr_fire;
  logic sck_fall;
  mpmc_state_e next_state;
  logic locked;
  logic wr_pwr;
  logic wr_opm;
  logic soft_rst;
  logic clear_user;
  logic [7:0] pwr_reg;
  logic [7:0] opm_reg;
  logic [7:0] rep_xy;
  logic [7:0] rep_z;
  logic [7:0] result;
  logic [7:0] trim_q [TRIM_WORDS];
  logic [7:0] boot_cnt;
  logic [31:0] meas_cnt;
  logic [31:0] meas_len;
  logic [31:0] odr_cnt;
  logic [31:0] odr_len;
  logic meas_go;
  logic meas_done;
  logic rd_blocked;
  logic [7:0] rd_val;
  logic [6:0] tx_rest;
  logic tx_skip;

  // =====================================================
  // link receiver, target only
  mpmc_spi_rx u_rx (
    .rst(rst),
    .link_sck(link_sck),
    .link_csb(link_csb),
    .link_sdi(link_sdi),
    .rd_tgl(rx_rd_tgl),
    .wr_tgl(rx_wr_tgl),
    .req_addr(rx_addr),
    .req_data(rx_wdata)
  );

  // =====================================================
  // crossings into the system clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_sy <= 3'h0;
      wr_sy <= 3'h0;
      sck_sy <= 3'h0;
      csb_sy <= 2'h3;
      i2c_sy <= 2'h0;
    end else begin
      rd_sy <= {rd_sy[1:0], rx_rd_tgl};
      wr_sy <= {wr_sy[1:0], rx_wr_tgl};
      sck_sy <= {sck_sy[1:0], link_sck};
      csb_sy <= {csb_sy[0], link_csb};
      i2c_sy <= {i2c_sy[0], proto_i2c};
    end
  end

  assign rd_fire = rd_sy[2] ^ rd_sy[1];
  assign wr_fire = wr_sy[2] ^ wr_sy[1];
  assign sck_fall = sck_sy[2] & ~sck_sy[1];

  // =====================================================
  // access decode
  assign locked = (power_mode == MPMC_BOOT) || (power_mode == MPMC_SUSPEND);
  assign wr_pwr = wr_fire && (rx_addr == `MPMC_ADDR_PWR) && (power_mode != MPMC_BOOT);
  assign wr_opm = wr_fire && (rx_addr == `MPMC_ADDR_OPM) && !locked;
  assign soft_rst = wr_pwr && !locked && rx_wdata[`MPMC_PWR_ON_BIT] && rx_wdata[`MPMC_PWR_SRST_BIT];

  // =====================================================
  // power mode sequencing
  always_comb begin
    next_state = power_mode;
    case (power_mode)
      MPMC_BOOT: begin
        if (boot_cnt == 8'(TRIM_WORDS)) begin
          next_state = MPMC_SUSPEND;
        end
      end
      MPMC_SUSPEND: begin
        if (wr_pwr && rx_wdata[`MPMC_PWR_ON_BIT]) begin
          next_state = MPMC_SLEEP;
        end
      end
      MPMC_SLEEP, MPMC_NORMAL, MPMC_FORCED: begin
        if (wr_pwr && !rx_wdata[`MPMC_PWR_ON_BIT]) begin
          next_state = MPMC_SUSPEND;
        end else if (soft_rst) begin
          next_state = MPMC_SLEEP;
        end else if (wr_opm) begin
          case (rx_wdata[`MPMC_OPM_HI:`MPMC_OPM_LO])
            `MPMC_CODE_NORMAL: next_state = MPMC_NORMAL;
            `MPMC_CODE_FORCED: next_state = MPMC_FORCED;
            default: next_state = MPMC_SLEEP;
          endcase
        end else if (power_mode == MPMC_FORCED && meas_done) begin
          next_state = MPMC_SLEEP;
        end
      end
      default: next_state = MPMC_SUSPEND;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_mode <= MPMC_BOOT;
    end else begin
      power_mode <= next_state;
    end
  end

  assign clear_user = ((next_state == MPMC_SUSPEND) && (power_mode != MPMC_SUSPEND)) || soft_rst;

  // =====================================================
  // start-up copy of trim content
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boot_cnt <= 8'h00;
      trim_addr <= 8'h00;
    end else begin
      trim_addr <= boot_cnt;
      if (power_mode == MPMC_BOOT && boot_cnt != 8'(TRIM_WORDS)) begin
        boot_cnt <= boot_cnt + 8'h01;
      end
    end
  end

  for (genvar i = 0; i < TRIM_WORDS; i++) begin : g_trim
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        trim_q[i] <= 8'h00;
      end else if (power_mode == MPMC_BOOT && boot_cnt != 8'h00 && trim_addr == 8'(i)) begin
        trim_q[i] <= trim_data;
      end
    end
  end

  // =====================================================
  // user registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_reg <= `MPMC_PWR_RST;
    end else if (wr_pwr) begin
      pwr_reg <= rx_wdata & `MPMC_PWR_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      opm_reg <= `MPMC_OPM_RST;
    end else if (clear_user) begin
      opm_reg <= `MPMC_OPM_RST;
    end else if (wr_opm) begin
      opm_reg <= rx_wdata & `MPMC_OPM_MASK;
    end else if (power_mode == MPMC_FORCED && meas_done) begin
      opm_reg[`MPMC_OPM_HI:`MPMC_OPM_LO] <= `MPMC_CODE_SLEEP;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rep_xy <= `MPMC_REP_RST;
      rep_z <= `MPMC_REP_RST;
    end else if (clear_user) begin
      rep_xy <= `MPMC_REP_RST;
      rep_z <= `MPMC_REP_RST;
    end else if (wr_fire && !locked) begin
      if (rx_addr == `MPMC_ADDR_REPXY) begin
        rep_xy <= rx_wdata;
      end
      if (rx_addr == `MPMC_ADDR_REPZ) begin
        rep_z <= rx_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result <= 8'h00;
    end else if (clear_user) begin
      result <= 8'h00;
    end else if (meas_done) begin
      result <= meas_sample;
    end
  end

  // =====================================================
  // measurement pacing
  assign meas_len = 32'(T_XY_CYC * {24'h0, rep_xy}) + 32'(T_Z_CYC * {24'h0, rep_z}) + T_BASE_CYC;
  assign odr_len = opm_reg[`MPMC_ODR_BIT] ? (ODR_CYC >> 1) : ODR_CYC;
  assign meas_go = (wr_opm && next_state == MPMC_FORCED)
                   || (power_mode == MPMC_NORMAL && next_state == MPMC_NORMAL && odr_cnt == 32'h0);
  assign meas_done = meas_active && (meas_cnt == 32'h1) && !meas_go;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      odr_cnt <= 32'h0;
    end else if (power_mode != MPMC_NORMAL) begin
      odr_cnt <= 32'h0;
    end else if (odr_cnt == 32'h0) begin
      odr_cnt <= odr_len - 32'h1;
    end else begin
      odr_cnt <= odr_cnt - 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meas_active <= 1'b0;
      meas_cnt <= 32'h0;
    end else if (meas_go) begin
      meas_active <= 1'b1;
      meas_cnt <= meas_len;
    end else if (meas_done || (next_state != MPMC_NORMAL && next_state != MPMC_FORCED)) begin
      meas_active <= 1'b0;
    end else if (meas_active) begin
      meas_cnt <= meas_cnt - 32'h1;
    end
  end

  // =====================================================
  // read data
  assign rd_blocked = locked && (rx_addr != `MPMC_ADDR_PWR);

  always_comb begin
    rd_val = 8'h00;
    case (rx_addr)
      `MPMC_ADDR_ID: rd_val = DEV_ID;
      `MPMC_ADDR_PWR: rd_val = pwr_reg;
      `MPMC_ADDR_OPM: rd_val = {meas_active, opm_reg[6:0]};
      `MPMC_ADDR_REPXY: rd_val = rep_xy;
      `MPMC_ADDR_REPZ: rd_val = rep_z;
      `MPMC_ADDR_RES: rd_val = result;
      default: begin
        for (int i = 0; i < TRIM_WORDS; i++) begin
          if (rx_addr == 7'(`MPMC_ADDR_TRIM + i)) begin
            rd_val = trim_q[i];
          end
        end
      end
    endcase
    if (rd_blocked) begin
      rd_val = 8'h00;
    end
  end

  // =====================================================
  // serial output
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_sdo <= 1'b0;
      link_sdo_oe <= 1'b0;
      tx_rest <= 7'h00;
      tx_skip <= 1'b0;
    end else if (rd_fire) begin
      {link_sdo, tx_rest} <= rd_val;
      link_sdo_oe <= !(rd_blocked && !i2c_sy[1]);
      tx_skip <= 1'b1;
    end else if (csb_sy[1]) begin
      link_sdo_oe <= 1'b0;
    end else if (sck_fall) begin
      if (tx_skip) begin
        tx_skip <= 1'b0;
      end else begin
        {link_sdo, tx_rest} <= {tx_rest, 1'b0};
      end
    end
  end

  // =====================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  boot_to_suspend_a: assert property (
    power_mode == MPMC_BOOT && boot_cnt == 8'(TRIM_WORDS) |=> power_mode == MPMC_SUSPEND)
    else $error("start-up did not end in suspend");
  suspend_block_a: assert property (
    wr_fire && locked && rx_addr != `MPMC_ADDR_PWR |=> $stable(opm_reg) && $stable(rep_xy) && $stable(rep_z))
    else $error("register written while suspended");
  suspend_clear_a: assert property (
    power_mode == MPMC_SUSPEND |-> opm_reg == `MPMC_OPM_RST && result == 8'h00 && rep_z == `MPMC_REP_RST)
    else $error("register content kept in suspend");
  id_hiz_a: assert property (
    rd_fire && power_mode == MPMC_SUSPEND && rx_addr == `MPMC_ADDR_ID && !i2c_sy[1] |=> !link_sdo_oe)
    else $error("identifier driven in suspend");
  id_zero_a: assert property (
    rd_fire && power_mode == MPMC_SUSPEND && rx_addr == `MPMC_ADDR_ID && i2c_sy[1] |=> link_sdo_oe && !link_sdo)
    else $error("identifier not zero in suspend");
  wake_sleep_a: assert property (
    power_mode == MPMC_SUSPEND && wr_pwr && rx_wdata[`MPMC_PWR_ON_BIT] |=> power_mode == MPMC_SLEEP)
    else $error("power bit did not wake to sleep");
  code_sleep_a: assert property (
    (power_mode == MPMC_NORMAL || power_mode == MPMC_FORCED) && wr_opm
    && rx_wdata[`MPMC_OPM_HI:`MPMC_OPM_LO] == `MPMC_CODE_SLEEP |=> power_mode == MPMC_SLEEP)
    else $error("sleep code ignored");
  power_off_a: assert property (
    !locked && wr_pwr && !rx_wdata[`MPMC_PWR_ON_BIT] |=> power_mode == MPMC_SUSPEND)
    else $error("power bit clear did not suspend");
  normal_start_a: assert property (
    power_mode == MPMC_SLEEP && wr_opm && rx_wdata[`MPMC_OPM_HI:`MPMC_OPM_LO] == `MPMC_CODE_NORMAL
    |=> power_mode == MPMC_NORMAL ##1 meas_active)
    else $error("normal mode did not start measuring");
  normal_load_a: assert property (
    power_mode == MPMC_NORMAL && meas_done && !clear_user |=> result == $past(meas_sample))
    else $error("normal result not loaded");
  soft_sleep_a: assert property (
    power_mode == MPMC_NORMAL && soft_rst |=> power_mode == MPMC_SLEEP && opm_reg == `MPMC_OPM_RST)
    else $error("soft reset did not give sleep");
  forced_end_a: assert property (
    power_mode == MPMC_FORCED && meas_done && !wr_fire
    |=> power_mode == MPMC_SLEEP && opm_reg[`MPMC_OPM_HI:`MPMC_OPM_LO] == `MPMC_CODE_SLEEP)
    else $error("forced measurement did not return to sleep");
  retrigger_drop_a: assert property (
    meas_go && meas_active && !clear_user |=> $stable(result) && meas_cnt == $past(meas_len))
    else $error("partial result written on retrigger");
endmodule
`default_nettype wire

// ===== testbench/mpmc_host_model.sv
// host controller model driving the four-wire link of the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module mpmc_host_model (
  // link pins
  output logic link_sck,
  output logic link_csb,
  output logic link_sdi,
  input wire logic link_sdo,
  input wire logic link_sdo_oe,
  // read results
  output logic rd_strobe,
  output logic [7:0] rd_byte,
  output logic rd_oe_seen
);
  localparam realtime T_HALF = 62.5;
  logic last_lvl;
  logic line_lvl;

  // =====================================================
  // line level
  initial begin
    link_sck = 1'b0;
    link_csb = 1'b1;
    link_sdi = 1'b0;
    rd_strobe = 1'b0;
    rd_byte = 8'h00;
    rd_oe_seen = 1'b0;
    last_lvl = 1'b0;
  end
  // a released line shows the inverse of its last driven level
  always @(link_sdo or link_sdo_oe) begin
    if (link_sdo_oe) begin
      last_lvl = link_sdo;
    end
  end
  assign line_lvl = link_sdo_oe ? link_sdo : ~last_lvl;

  // =====================================================
  // frames, clock stands still between them
  task automatic bit_out(input logic b);
    link_sdi = b;
    #(T_HALF);
    link_sck = 1'b1;
    #(T_HALF);
    link_sck = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
  endtask
  task automatic frame_end();
    #(T_HALF);
    link_csb = 1'b1;
    #(250);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    #(37);
    link_csb = 1'b0;
    byte_out({1'b0, a});
    byte_out(d);
    frame_end();
  endtask
  task automatic wr2(input logic [6:0] a, input logic [15:0] d);
    #(37);
    link_csb = 1'b0;
    byte_out({1'b0, a});
    byte_out(d[15:8]);
    byte_out(d[7:0]);
    frame_end();
  endtask
  task automatic rd(input logic [6:0] a);
    logic [7:0] b;
    #(37);
    link_csb = 1'b0;
    byte_out({1'b1, a});
    rd_oe_seen = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(T_HALF);
      link_sck = 1'b1;
      b[i] = line_lvl;
      rd_oe_seen = rd_oe_seen | link_sdo_oe;
      #(T_HALF);
      link_sck = 1'b0;
    end
    rd_byte = b;
    rd_strobe = 1'b1;
    #1 rd_strobe = 1'b0;
    frame_end();
  endtask
endmodule
`default_nettype wire

// ===== testbench/mpmc_tb_top.sv
// self-checking testbench of the power-mode sequencer
`include "mpmc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mpmc_tb_top
  import mpmc_pkg::*;
();
  localparam logic [7:0] DEV_ID = 8'h3c; // arbitrary value
  localparam int MEAS_CYC = 3 * 3 + 5 * 3 + 240;
  localparam logic [7:0] OPM_NORMAL = 8'h00;
  localparam logic [7:0] OPM_FORCED = 8'h02;
  localparam logic [7:0] OPM_ODD = 8'h04;
  typedef struct {
    logic [1:0] kind;
    logic [7:0] exp;
    string what;
  } mpmc_note_s;
  logic clk_sys, rst, proto_i2c, probe;
  logic link_sck, link_csb, link_sdi, link_sdo, link_sdo_oe;
  logic rd_strobe, rd_oe_seen, meas_active;
  logic [7:0] rd_byte, trim_addr, trim_data, meas_sample, seen, s_exp, s_old;
  logic [7:0] trim_tab [4];
  mpmc_state_e power_mode;
  mpmc_note_s notes [$];
  mpmc_note_s cur;
  int fails = 0;
  int checked = 0;
  int seed;

  // =====================================================
  // design and host
  mpmc_top #(.DEV_ID(DEV_ID), .TRIM_WORDS(4), .T_XY_CYC(32'd3), .T_Z_CYC(32'd5), .T_BASE_CYC(32'd240),
    .ODR_CYC(32'd400)) i_mpmc_top (.clk_sys(clk_sys), .rst(rst), .link_sck(link_sck), .link_csb(link_csb),
    .link_sdi(link_sdi), .proto_i2c(proto_i2c), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
    .trim_addr(trim_addr), .trim_data(trim_data), .meas_sample(meas_sample), .meas_active(meas_active),
    .power_mode(power_mode));
  mpmc_host_model i_mpmc_host_model (.link_sck(link_sck), .link_csb(link_csb), .link_sdi(link_sdi),
    .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe), .rd_strobe(rd_strobe), .rd_byte(rd_byte),
    .rd_oe_seen(rd_oe_seen));
  assign trim_data = trim_tab[trim_addr[1:0]];

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // =====================================================
  // tasks
  task automatic print_verdict();
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic note(input logic [1:0] k, input logic [7:0] e, input string w);
    mpmc_note_s n;
    n.kind = k;
    n.exp = e;
    n.what = w;
    notes.push_back(n);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string w);
    @(posedge clk_sys);
    #1 note(2'd0, e, w);
    i_mpmc_host_model.rd(a);
  endtask
  task automatic rel_chk(input logic [6:0] a);
    @(posedge clk_sys);
    #1 note(2'd2, 8'h00, "link_sdo_oe");
    i_mpmc_host_model.rd(a);
  endtask
  task automatic mode_chk(input mpmc_state_e m);
    @(posedge clk_sys);
    #1 note(2'd1, {5'h00, m}, "power_mode");
    probe = 1'b1;
    #1 probe = 1'b0;
  endtask
  task automatic act_chk(input logic e);
    @(posedge clk_sys);
    #1 note(2'd3, {7'h00, e}, "meas_active");
    probe = 1'b1;
    #1 probe = 1'b0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 i_mpmc_host_model.wr(a, d);
  endtask
  task automatic set_reps();
    @(posedge clk_sys);
    #1 i_mpmc_host_model.wr2(`MPMC_ADDR_REPXY, 16'h0303);
  endtask
  task automatic new_sample();
    @(posedge clk_sys);
    #1 meas_sample = 8'($random(seed));
    s_exp = meas_sample;
  endtask

  // =====================================================
  // result monitor
  always @(posedge rd_strobe or posedge probe) begin
    if (notes.size() == 0) begin
      fails++;
      $display("MISMATCH note_queue expected entry seen none");
    end else begin
      cur = notes.pop_front();
      checked++;
      seen = (cur.kind == 2'd0) ? rd_byte : (cur.kind == 2'd1) ? {5'h00, power_mode} :
        (cur.kind == 2'd2) ? {7'h00, rd_oe_seen} : {7'h00, meas_active};
      if (seen !== cur.exp) begin
        fails++;
        $display("MISMATCH %s expected %h seen %h", cur.what, cur.exp, seen);
      end
    end
  end

  initial begin
    #(300000);
    fails++;
    print_verdict();
  end

  // =====================================================
  // main sequence
  initial begin
    seed = 56569;
    rst = 1'b1;
    proto_i2c = 1'b1;
    probe = 1'b0;
    meas_sample = 8'h00;
    for (int i = 0; i < 4; i++) trim_tab[i] = 8'($random(seed));
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    mode_chk(MPMC_BOOT);
    repeat (6) @(posedge clk_sys);
    mode_chk(MPMC_SUSPEND);
    rd_chk(`MPMC_ADDR_ID, 8'h00, "id_blocked");
    @(posedge clk_sys);
    #1 proto_i2c = 1'b0;
    rel_chk(`MPMC_ADDR_ID);
    rel_chk(`MPMC_ADDR_OPM);
    @(posedge clk_sys);
    #1 proto_i2c = 1'b1;
    wr(`MPMC_ADDR_REPXY, 8'h33);
    wr(`MPMC_ADDR_PWR, 8'h01);
    mode_chk(MPMC_SLEEP);
    rd_chk(`MPMC_ADDR_ID, DEV_ID, "id_sleep");
    rd_chk(`MPMC_ADDR_REPXY, `MPMC_REP_RST, "repxy_blocked");
    rd_chk(`MPMC_ADDR_OPM, `MPMC_OPM_RST, "opm_default");
    rd_chk(7'h70, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) rd_chk(7'(`MPMC_ADDR_TRIM + i), trim_tab[i], "trim_shadow");
    set_reps();
    rd_chk(`MPMC_ADDR_REPZ, 8'h03, "repz");
    new_sample();
    wr(`MPMC_ADDR_OPM, OPM_NORMAL);
    mode_chk(MPMC_NORMAL);
    repeat (MEAS_CYC) @(posedge clk_sys);
    rd_chk(`MPMC_ADDR_RES, s_exp, "result_normal");
    new_sample();
    repeat (400) @(posedge clk_sys);
    rd_chk(`MPMC_ADDR_RES, s_exp, "result_next_period");
    wr(`MPMC_ADDR_OPM, `MPMC_OPM_RST);
    mode_chk(MPMC_SLEEP);
    wr(`MPMC_ADDR_OPM, OPM_NORMAL);
    wr(`MPMC_ADDR_PWR, 8'h04);
    mode_chk(MPMC_SUSPEND);
    rd_chk(`MPMC_ADDR_PWR, 8'h04, "pwr_retained");
    wr(`MPMC_ADDR_PWR, 8'h05);
    rd_chk(`MPMC_ADDR_REPXY, 8'h00, "repxy_lost");
    set_reps();
    wr(`MPMC_ADDR_OPM, OPM_NORMAL);
    wr(`MPMC_ADDR_PWR, 8'h07);
    mode_chk(MPMC_SLEEP);
    rd_chk(`MPMC_ADDR_PWR, 8'h05, "pwr_soft_reset");
    set_reps();
    new_sample();
    wr(`MPMC_ADDR_OPM, OPM_FORCED);
    mode_chk(MPMC_FORCED);
    act_chk(1'b1);
    rd_chk(`MPMC_ADDR_OPM, 8'h82, "opm_forced_busy");
    repeat (MEAS_CYC) @(posedge clk_sys);
    mode_chk(MPMC_SLEEP);
    act_chk(1'b0);
    rd_chk(`MPMC_ADDR_OPM, `MPMC_OPM_RST, "opm_forced_done");
    rd_chk(`MPMC_ADDR_RES, s_exp, "result_forced");
    wr(`MPMC_ADDR_OPM, OPM_ODD);
    mode_chk(MPMC_SLEEP);
    s_old = s_exp;
    new_sample();
    wr(`MPMC_ADDR_OPM, OPM_FORCED);
    wr(`MPMC_ADDR_OPM, OPM_FORCED);
    rd_chk(`MPMC_ADDR_RES, s_old, "result_discarded");
    repeat (MEAS_CYC) @(posedge clk_sys);
    mode_chk(MPMC_SLEEP);
    rd_chk(`MPMC_ADDR_RES, s_exp, "result_retriggered");
    print_verdict();
  end
endmodule
`default_nettype wire
